//--- core/asfc_top.sv
// sample buffer control: modes, fill mark, status/header read-back, apb registers
//
// Contract
// - status word sent once at read start
// - status once, header per sample
// - header word precedes each read sample
// - mode zero disables buffering, use data register
// - fill-mark mode keeps first N, drops rest; code drops a sample on rd_pop, keeps N+1 if N<256 with back-to-back samples
// - reading a sample frees its space
// - fill-mark drop raises overflow indicator
// - discard-oldest overwrites oldest, raises overflow
// - read-fault enable gates read-fault onto pin
// - upper-level enable gates upper indicator
// - lower-level enable gates lower indicator
// - overflow enable gates overflow indicator
// - empty interrupt same cycle as empty
// - fill mark 0x00 means 256 samples
// - errors raised only while buffering enabled
// - write-fault cleared when buffer emptied
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module asfc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_valid,
    input  wire logic [23:0] conv_data,
    input  wire logic [3:0]  conv_header,
    input  wire logic [7:0]  upper_level,
    input  wire logic [7:0]  lower_level,
    output logic             irq_pin
);
    ////////////////////////////////////////////////////////////////////////////////
    // registers and wires
    logic [23:0]                 ctrl_ff;       // sample_buffer_control
    logic [asfc_pkg::AW-1:0]     wptr_ff;       // write pointer
    logic [asfc_pkg::AW-1:0]     rptr_ff;       // read pointer
    logic [asfc_pkg::AW:0]       count_ff;      // stored entries 0..256
    logic                        locked_ff;     // fill-mark reached, drops until drained
    logic                        werr_ff;       // write-fault indicator
    logic                        rerr_ff;       // read-fault indicator
    logic                        ovr_ff;        // overflow indicator
    logic [23:0]                 conv_ff;       // last conversion, for data register
    logic [31:0]                 prdata_ff;
    logic                        pready_ff;
    logic                        pslverr_ff;
    logic                        irq_ff;
    asfc_pkg::asfc_rd_e          rd_st_ff;      // read-back sequencer
    logic                        stat_sent_ff;  // status word already sent this read
    logic [asfc_pkg::DW+3:0]     mem_rdata;
    logic [1:0]                  mode;
    logic [asfc_pkg::AW:0]       mark_level;
    logic                        buf_on;
    logic                        empty;
    logic                        full;
    logic                        mark_hit;
    logic                        upper_ind;
    logic                        lower_ind;
    logic [7:0]                  status;
    logic                        setup;
    logic                        acc;
    logic [7:0]                  idx;
    logic                        rd_pop;
    logic                        wr_take;
    logic                        wr_drop;
    logic                        wr_over;
    logic                        rd_fault;
    logic                        irq_nxt;
    logic [asfc_pkg::AW:0]       nxt_count;     // occupancy after this edge

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // fill-mark field to a sample count
    function automatic logic [asfc_pkg::AW:0] mark_count(input logic [7:0] f);
        mark_count = (f == 8'h00) ? 9'h100 : {1'b0, f};
    endfunction

    // apb address to printed register index
    function automatic logic [7:0] reg_index(input logic [11:0] a);
        reg_index = a[9:2];
    endfunction

    assign mode       = ctrl_ff[asfc_pkg::MODE_LSB +: 2];
    assign buf_on     = (mode != asfc_pkg::MODE_OFF);
    assign mark_level = mark_count(ctrl_ff[7:0]);
    assign empty      = (count_ff == 9'h000);
    assign full       = (count_ff == 9'h100);
    assign mark_hit   = (count_ff >= mark_level);
    assign upper_ind  = buf_on && (count_ff >= {1'b0, upper_level});
    assign lower_ind  = buf_on && (count_ff <= {1'b0, lower_level});
    assign setup      = psel && !penable;
    assign acc        = psel && penable && pready_ff;
    assign idx        = reg_index(paddr);

    // status word assembly
    always_comb begin
        status                     = 8'h00;
        status[asfc_pkg::ST_WERR]  = werr_ff;
        status[asfc_pkg::ST_RERR]  = rerr_ff;
        status[asfc_pkg::ST_UPPER] = upper_ind;
        status[asfc_pkg::ST_LOWER] = lower_ind;
        status[asfc_pkg::ST_OVR]   = ovr_ff;
        status[asfc_pkg::ST_MARK]  = buf_on && mark_hit;
        status[asfc_pkg::ST_EMPTY] = empty;
        status[asfc_pkg::ST_MASTER] = werr_ff || rerr_ff || ovr_ff;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read-back: a sample pop happens on the data word of a read-port access
    assign rd_pop   = acc && !pwrite && (idx == asfc_pkg::RDATA_INDEX) && buf_on && !empty
                      && (rd_st_ff == asfc_pkg::ASFC_DATA);
    assign rd_fault = acc && !pwrite && (idx == asfc_pkg::RDATA_INDEX) && buf_on && empty;

    // write side: keep, drop or overwrite
    always_comb begin
        wr_take = 1'b0;
        wr_drop = 1'b0;
        wr_over = 1'b0;
        if (conv_valid && buf_on) begin
            if (mode == asfc_pkg::MODE_MARK) begin
                if (locked_ff || full || rd_pop) begin
                    wr_drop = 1'b1;
                end else begin
                    wr_take = 1'b1;
                end
            end else if (full && !rd_pop) begin
                wr_over = 1'b1;
            end else begin
                wr_take = 1'b1;
            end
        end
    end

    // occupancy after this edge, so the empty interrupt rises with the indicator
    always_comb begin
        nxt_count = count_ff;
        if (wr_take && !rd_pop) begin
            nxt_count = count_ff + 9'h001;
        end else if (rd_pop && !wr_take) begin
            nxt_count = count_ff - 9'h001;
        end
    end

    asfc_mem u_mem (
        .pclk  (pclk),
        .we    (wr_take || wr_over),
        .waddr (wptr_ff),
        .wdata ({conv_header, conv_data}),
        .raddr (rd_pop ? rptr_ff + 8'h01 : rptr_ff),
        .rdata (mem_rdata)
    );

    // pointers and occupancy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_ff  <= '0;
            rptr_ff  <= '0;
            count_ff <= '0;
        end else if (!buf_on) begin
            wptr_ff  <= '0;
            rptr_ff  <= '0;
            count_ff <= '0;
        end else begin
            if (wr_take || wr_over) begin
                wptr_ff <= wptr_ff + 8'h01;
            end
            if (rd_pop || wr_over) begin
                rptr_ff <= rptr_ff + 8'h01;
            end
            count_ff <= nxt_count;
        end
    end

    // fill-mark lock: set at the mark, released once drained
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_ff <= 1'b0;
        end else if (mode != asfc_pkg::MODE_MARK || empty) begin
            locked_ff <= 1'b0;
        end else if (mark_hit) begin
            locked_ff <= 1'b1;
        end
    end

    // error indicators, only while buffering; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            werr_ff <= 1'b0;
            ovr_ff  <= 1'b0;
            rerr_ff <= 1'b0;
        end else if (!buf_on) begin
            werr_ff <= 1'b0;
            ovr_ff  <= 1'b0;
            rerr_ff <= 1'b0;
        end else begin
            if (wr_drop) begin
                werr_ff <= 1'b1;
            end else if (empty) begin
                werr_ff <= 1'b0;
            end
            if (wr_drop || wr_over) begin
                ovr_ff <= 1'b1;
            end else if (acc && !pwrite && idx == asfc_pkg::STAT_INDEX) begin
                ovr_ff <= 1'b0;
            end
            if (rd_fault) begin
                rerr_ff <= 1'b1;
            end else if (acc && !pwrite && idx == asfc_pkg::STAT_INDEX) begin
                rerr_ff <= 1'b0;
            end
        end
    end

    // last conversion for the ordinary data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_ff <= '0;
        end else if (conv_valid) begin
            conv_ff <= conv_data;
        end
    end

    // read-back sequencer: status once, then header and data per sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_st_ff     <= asfc_pkg::ASFC_IDLE;
            stat_sent_ff <= 1'b0;
        end else if (acc && !pwrite && idx == asfc_pkg::RDATA_INDEX && buf_on) begin
            unique case (rd_st_ff)
                asfc_pkg::ASFC_IDLE: begin
                    rd_st_ff     <= ctrl_ff[asfc_pkg::ADD_HDR_BIT] ? asfc_pkg::ASFC_HDR
                                                                   : asfc_pkg::ASFC_DATA;
                    stat_sent_ff <= 1'b1;
                end
                asfc_pkg::ASFC_HDR: begin
                    rd_st_ff <= asfc_pkg::ASFC_DATA;
                end
                asfc_pkg::ASFC_DATA: begin
                    rd_st_ff <= ctrl_ff[asfc_pkg::ADD_HDR_BIT] ? asfc_pkg::ASFC_HDR
                                                               : asfc_pkg::ASFC_DATA;
                end
            endcase
        end else if (setup && !(idx == asfc_pkg::RDATA_INDEX && !pwrite)) begin
            rd_st_ff     <= asfc_pkg::ASFC_IDLE;  // other access ends the read
            stat_sent_ff <= 1'b0;
        end else if (rd_st_ff == asfc_pkg::ASFC_IDLE && setup
                     && !ctrl_ff[asfc_pkg::ADD_STAT_BIT]) begin
            rd_st_ff <= ctrl_ff[asfc_pkg::ADD_HDR_BIT] ? asfc_pkg::ASFC_HDR
                                                       : asfc_pkg::ASFC_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, data and answer from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= psel && penable && !pready_ff;  // one wait state after setup
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
            if (psel && penable && !pready_ff) begin
                unique case (idx)
                    asfc_pkg::CTRL_INDEX: prdata_ff <= {8'h00, ctrl_ff};
                    asfc_pkg::STAT_INDEX: prdata_ff <= {24'h000000, status};
                    asfc_pkg::CONV_INDEX: prdata_ff <= {8'h00, conv_ff};
                    asfc_pkg::FLAG_INDEX: prdata_ff <= {31'h00000000, irq_ff};
                    asfc_pkg::RDATA_INDEX: begin
                        if (rd_st_ff == asfc_pkg::ASFC_IDLE) begin
                            prdata_ff <= {asfc_pkg::TAG_STATUS, 22'h000000, status};
                        end else if (rd_st_ff == asfc_pkg::ASFC_HDR) begin
                            prdata_ff <= {asfc_pkg::TAG_HEADER, 26'h0000000,
                                          mem_rdata[27:24]};
                        end else begin
                            prdata_ff <= {asfc_pkg::TAG_DATA, 6'h00, mem_rdata[23:0]};
                        end
                    end
                    default: pslverr_ff <= asfc_pkg::PSLVERR_UNMAP;
                endcase
            end
        end
    end

    // control register write; reserved top bits held at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= asfc_pkg::CTRL_RESET;
        end else if (acc && pwrite && idx == asfc_pkg::CTRL_INDEX) begin
            ctrl_ff <= pwdata[23:0] & asfc_pkg::CTRL_WMASK;
        end
    end

    // enables route indicators onto the interrupt pin
    always_comb begin
        irq_nxt = (ctrl_ff[asfc_pkg::RERR_EN_BIT]  && rerr_ff)
               || (ctrl_ff[asfc_pkg::UPPER_EN_BIT] && upper_ind)
               || (ctrl_ff[asfc_pkg::LOWER_EN_BIT] && lower_ind)
               || (ctrl_ff[asfc_pkg::OVR_EN_BIT]   && ovr_ff)
               || (ctrl_ff[asfc_pkg::WERR_EN_BIT]  && werr_ff)
               || (ctrl_ff[asfc_pkg::MARK_EN_BIT]  && buf_on && mark_hit)
               || (ctrl_ff[asfc_pkg::EMPTY_EN_BIT] && buf_on
                   && nxt_count == 9'h000);
    end

    // interrupt pin register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irq_nxt;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq_pin = irq_ff;
endmodule // asfc_top

//--- core/asfc_pkg.sv
// package: register map, field layout, reset values and codes of the sample buffer control
package asfc_pkg;
    // register indices as printed (0x3a is not a multiple of four), byte address is index*4
    localparam logic [7:0]  CTRL_INDEX     = 8'h3a;   // sample_buffer_control
    localparam logic [7:0]  STAT_INDEX     = 8'h3b;   // buffer status word
    localparam logic [7:0]  RDATA_INDEX    = 8'h3c;   // buffer read-back port
    localparam logic [7:0]  CONV_INDEX     = 8'h3d;   // ordinary conversion data
    localparam logic [7:0]  FLAG_INDEX     = 8'h3e;   // interrupt pin level in bit 0
    localparam logic [23:0] CTRL_RESET     = 24'h040200;
    localparam logic [23:0] CTRL_WMASK     = 24'h0fffff;   // top four bits read zero
    // control field positions
    localparam int          ADD_STAT_BIT   = 19;
    localparam int          ADD_HDR_BIT    = 18;
    localparam int          MODE_LSB       = 16;
    localparam int          WERR_EN_BIT    = 14;
    localparam int          RERR_EN_BIT    = 13;
    localparam int          UPPER_EN_BIT   = 12;
    localparam int          LOWER_EN_BIT   = 11;
    localparam int          OVR_EN_BIT     = 10;
    localparam int          MARK_EN_BIT    = 9;
    localparam int          EMPTY_EN_BIT   = 8;
    // status word bit positions
    localparam int          ST_MASTER      = 7;
    localparam int          ST_WERR        = 5;
    localparam int          ST_RERR        = 4;
    localparam int          ST_UPPER       = 3;
    localparam int          ST_LOWER       = 2;
    localparam int          ST_OVR         = 1;
    localparam int          ST_MARK        = 6;
    localparam int          ST_EMPTY       = 0;
    // buffer geometry
    localparam int          DEPTH          = 256;
    localparam int          AW             = 8;
    localparam int          DW             = 24;
    // buffering modes
    localparam logic [1:0]  MODE_OFF       = 2'h0;
    localparam logic [1:0]  MODE_MARK      = 2'h1;
    // read-back word tags in bits [31:30]
    localparam logic [1:0]  TAG_STATUS     = 2'h1;
    localparam logic [1:0]  TAG_HEADER     = 2'h2;
    localparam logic [1:0]  TAG_DATA       = 2'h3;
    // apb error answer for unmapped addresses
    localparam logic        PSLVERR_UNMAP  = 1'h1;
    // read-back sequencer states
    typedef enum logic [1:0] {
        ASFC_IDLE,
        ASFC_HDR,
        ASFC_DATA
    } asfc_rd_e;
endpackage

//--- core/asfc_mem.sv
// sample memory: one write port, registered read port
`timescale 1ns/1ps
module asfc_mem (
    input  wire logic                     pclk,
    input  wire logic                     we,
    input  wire logic [asfc_pkg::AW-1:0]  waddr,
    input  wire logic [asfc_pkg::DW+3:0]  wdata,
    input  wire logic [asfc_pkg::AW-1:0]  raddr,
    output logic      [asfc_pkg::DW+3:0]  rdata
);
    logic [asfc_pkg::DW+3:0] mem [asfc_pkg::DEPTH];  // sample with 4-bit header

    // write port
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge pclk) begin
        rdata <= mem[raddr];
    end
endmodule // asfc_mem

//--- sim/asfc_top_properties.sv
// checker: apb timing, register and read-back relations of the sample buffer control
`timescale 1ns/1ps
module asfc_top_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        conv_valid,
    input wire logic [23:0] conv_data,
    input wire logic [3:0]  conv_header,
    input wire logic [7:0]  upper_level,
    input wire logic [7:0]  lower_level,
    input wire logic        irq_pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [6:0] en_ff;   // shadow of the interrupt enables
    logic       stat_ff; // shadow of the status-append bit
    logic [1:0] mode_ff; // shadow of the mode field
    logic       run_ff;  // last completed access was a read-port read
    ////////////////////////////////////////////////////////////////
    // shadow control register, updated only when a transfer completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= 7'h02;
            stat_ff <= 1'b0;
            mode_ff <= 2'h0;
            run_ff <= 1'b0;
        end else if (psel && penable && pready) begin
            if (pwrite && paddr == 12'h0e8) begin
                en_ff <= pwdata[14:8];
                stat_ff <= pwdata[19];
                mode_ff <= pwdata[17:16];
            end
            run_ff <= !pwrite && paddr == 12'h0f0;
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        ##2 (pready && psel && penable);
    endsequence
    answer_timing_a: assert property (s_setup |-> s_answer) else $error("late answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
    slverr_pair_a: assert property (pslverr |-> pready) else $error("lone pslverr");
    unmap_err_a: assert property (s_setup |-> ##2 (pslverr == (paddr < 12'h0e8 || paddr > 12'h0f8)))
        else $error("bad pslverr");
    reserved_zero_a: assert property (s_setup ##0 (!pwrite && paddr == 12'h0e8) |->
        ##2 prdata[31:20] == 12'h000) else $error("reserved bits set");
    irq_gated_a: assert property ((en_ff == 7'h00) [*3] |-> !irq_pin)
        else $error("irq while disabled");
    mode_off_clean_a: assert property (s_setup ##0 (!pwrite && paddr == 12'h0ec &&
        mode_ff == 2'h0) |-> ##2 prdata[5:1] == 5'h00) else $error("error flag while off");
    status_first_a: assert property (s_setup ##0 (!pwrite && paddr == 12'h0f0 && !run_ff
        && stat_ff && mode_ff != 2'h0) |-> ##2 prdata[31:30] == 2'h1) else $error("no status");
endmodule // asfc_top_properties
bind asfc_top asfc_top_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_header(conv_header), .upper_level(upper_level), .lower_level(lower_level),
    .irq_pin(irq_pin));

//--- sim/asfc_host.sv
// host model: apb master issuing one transfer at a time
`timescale 1ns/1ps
module asfc_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    ////////////////////////////////////////////////////////////////
    // one transfer; ok low if no answer came within the bound
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic ok);
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d & 32'hffff7fff;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(posedge pclk);
            ok = pready;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~pwdata; // released data does not keep its value
    endtask
endmodule // asfc_host

//--- sim/adc_sample_fifo_control_test.sv
// testbench: sample buffer control against a queue model
`timescale 1ns/1ps
module adc_sample_fifo_control_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_pin, err, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [23:0] conv_data;
    logic [3:0]  conv_header;
    logic [7:0]  upper_level, lower_level;
    logic        conv_valid, locked, ovr, hdr, stat;
    logic [27:0] model[$]; // expected contents, header over sample
    int          err_count, checks_done, seed, mode, lim;
    always #5 pclk = ~pclk;
    asfc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_valid(conv_valid), .conv_data(conv_data),
        .conv_header(conv_header), .upper_level(upper_level), .lower_level(lower_level),
        .irq_pin(irq_pin));
    asfc_host i_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    ////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(w, a, d, rd, err, ok);
        if (!ok) begin
            err_count++;
            stop_test();
        end
    endtask
    // pulse n conversions and update the model by mode
    task automatic push(input int n);
        repeat (n) begin
            @(posedge pclk);
            v = $random(seed);
            conv_valid <= 1'b1;
            conv_data <= v[23:0];
            conv_header <= v[27:24];
            if (mode == 1) begin
                if (locked) ovr = 1'b1;
                else model.push_back(v[27:0]);
                if (model.size() == lim) locked = 1'b1;
            end else if (mode == 2) begin
                if (model.size() == lim) begin
                    void'(model.pop_front());
                    ovr = 1'b1;
                end
                model.push_back(v[27:0]);
            end
            @(posedge pclk);
            conv_valid <= 1'b0;
        end
    endtask
    // read the whole buffer through the read port
    task automatic drain;
        if (stat) begin
            acc(1'b0, 12'h0f0, 32'h0);
            check({rd[31:30], rd[1]}, {asfc_pkg::TAG_STATUS, ovr});
        end
        while (model.size() > 0) begin
            if (hdr) begin
                acc(1'b0, 12'h0f0, 32'h0);
                check({rd[31:30], rd[3:0]}, {asfc_pkg::TAG_HEADER, model[0][27:24]});
            end
            acc(1'b0, 12'h0f0, 32'h0);
            v = model.pop_front();
            check({rd[31:30], rd[23:0]}, {asfc_pkg::TAG_DATA, v[23:0]});
        end
        locked = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 66;
        pclk = 1'b0;
        presetn = 1'b0;
        conv_valid = 1'b0;
        conv_data = 24'h0;
        conv_header = 4'h0;
        upper_level = 8'hff;
        lower_level = 8'h00;
        {err_count, checks_done, mode, lim, locked, ovr, hdr, stat} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, 12'h0e8, 32'h0);
        check(rd, 32'h00040200);
        acc(1'b1, 12'h0e8, 32'hfff00000);
        acc(1'b0, 12'h0e8, 32'h0);
        check(rd, 32'h0);
        acc(1'b0, 12'h0fc, 32'h0);
        check(err, 1'b1);
        push(3);
        acc(1'b0, 12'h0f4, 32'h0);
        check(rd, {8'h00, v[23:0]});
        acc(1'b0, 12'h0ec, 32'h0);
        check(rd[5:1], 5'h00);
        // empty reaches the pin only when enabled, read-fault when enabled
        acc(1'b1, 12'h0e8, 32'h00010104);
        repeat (2) @(posedge pclk);
        check(irq_pin, 1'b1);
        acc(1'b1, 12'h0e8, 32'h00012004);
        acc(1'b0, 12'h0f0, 32'h0);
        repeat (2) @(posedge pclk);
        check(irq_pin, 1'b1);
        acc(1'b0, 12'h0ec, 32'h0);
        check(rd[4], 1'b1);
        repeat (2) @(posedge pclk);
        check(irq_pin, 1'b0);
        // fill-mark mode, four kept, two dropped, then reopened
        {mode, lim, hdr, stat} = {32'd1, 32'd4, 2'b11};
        acc(1'b1, 12'h0e8, 32'h000d0004);
        push(6);
        drain();
        acc(1'b0, 12'h0ec, 32'h0);
        check({rd[5], rd[0]}, 2'b01);
        ovr = 1'b0;
        push(2);
        drain();
        // discard-oldest with a full-buffer mark
        {mode, lim, hdr, stat} = {32'd2, 32'd256, 2'b00};
        acc(1'b1, 12'h0e8, 32'h00020500);
        push(255);
        acc(1'b0, 12'h0ec, 32'h0);
        check(rd[6], 1'b0);
        push(1);
        acc(1'b0, 12'h0ec, 32'h0);
        check(rd[6], 1'b1);
        push(2);
        repeat (2) @(posedge pclk);
        check(irq_pin, 1'b1);
        acc(1'b0, 12'h0ec, 32'h0);
        check(rd[1], ovr);
        drain();
        @(posedge pclk);
        check(irq_pin, 1'b1);
        acc(1'b0, 12'h0ec, 32'h0);
        check(rd[0], 1'b1);
        stop_test();
    end
endmodule // adc_sample_fifo_control_test
